// ==== rtl/alm_regs.svh ====
// Register offsets, field positions and reset values of the alarm block.
// Assumes a byte-addressed Wishbone with one 32-bit word per register.
`ifndef ALM_REGS_SVH
`define ALM_REGS_SVH

// Printed offsets are register indices; byte address is four times the index.
`define ALM_IDX_SUMMARY     12'h2c0
`define ALM_IDX_FLAG_BANK   12'h2c1
`define ALM_IDX_MASK        12'h2c2
`define ALM_IDX_LANE_FAULT  12'h2c4
`define ALM_IDX_CAL_SEL     12'h2c6

`define ALM_NUM_SRC         6
`define ALM_NUM_LANES       16
`define ALM_FLAGS_RST       6'h3f
`define ALARM_SOURCE_MASK_RST        6'h3f
`define ALM_RSV_RST         2'h0
`define ALM_RDATA_RST       32'h0
`define ALM_LANE_RST        16'hffff
`define ALM_CAL_SEL_RST     2'h0
`define ALM_CAL_SEL_ALARM   2'h1

`define ALM_BIT_FIFO        5
`define ALM_BIT_LOCK        4
`define ALM_BIT_LINK        3
`define ALM_BIT_REALIGN     2
`define ALM_BIT_OSC         1
`define ALM_BIT_DIV         0

`endif

// ==== rtl/alm_pkg.sv ====
// Types shared by the alarm block.
// Assumes nothing beyond the register header.
package alm_pkg;

  // Wishbone request as seen by the slave.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [13:0] adr;
    logic [31:0] dat;
  } alm_wb_req_t;

  // Six alarm sources in register bit order.
  typedef struct packed {
    logic fifo_fault;
    logic lock_loss;
    logic link_fault;
    logic realign_event;
    logic osc_phase_upset;
    logic divider_mismatch;
  } alm_src_t;

endpackage

// ==== rtl/alm_sticky_bit.sv ====
// One sticky flag: set by an event, cleared by a write of one.
// Assumes the event and clear are in the clk_i domain.
`timescale 1ns/1ps
module alm_sticky_bit #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_q;
  logic flag_d;

  // Set wins over a clear arriving in the same cycle.
  assign flag_d = set_i | (flag_q & ~clr_i);
  assign flag_o = flag_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= RST_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// ==== rtl/alm_ctrl.sv ====
// What this block does
// RQ1: Mask bit 5 keeps the lane FIFO flag out of the summary alarm.
// RQ2: Mask bit 4 keeps the lock-loss flag out of the summary alarm.
// RQ3: Mask bit 3 keeps the link fault flag out of the summary alarm.
// RQ4: Mask bit 2 keeps the realign flag out of the summary alarm.
// RQ5: Mask bit 1 keeps the oscillator phase flag out of the summary alarm.
// RQ6: Mask bit 0 keeps the divider mismatch flag out; mask bits 7:6 are reserved.
// RQ7: After reset all six mask bits are one.
// RQ8: Lane bit i sets whenever the FIFO of lane i overflows or underflows.
// RQ9: Writing one to a lane bit clears it.
// RQ10: A lane whose fault persists sets its bit again at once.
// RQ11: After reset all sixteen lane bits read as set.
// RQ12: Writing zero to a lane bit leaves it, and mask writes store their value.
// RQ13: The summary alarm follows flag or mask changes within one cycle.
// RQ14: The summary alarm is one when any set flag has a clear mask bit.
// RQ15: Each of the six flags is set by its event, is one after reset, clears on write one.
// RQ16: The FIFO flag sets whenever any active lane FIFO faults.
// RQ17: When the pin select asks for it, the summary alarm drives the cal status pin.
//
// Alarm aggregation with a classic Wishbone slave, ack one cycle after a request.
// Assumes event inputs are pulses or levels already in the clk_i domain.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module alm_ctrl (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [13:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic [15:0]          lane_fifo_fault_i,
  input  wire logic [15:0]          lane_active_i,
  input  wire logic                 lock_loss_i,
  input  wire logic                 link_fault_i,
  input  wire logic                 realign_event_i,
  input  wire logic                 osc_phase_upset_i,
  input  wire logic                 divider_mismatch_i,
  input  wire logic                 cal_status_i,
  output logic                      cal_status_pin_o,
  output logic                      irq_o
);

  `include "alm_regs.svh"

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  alm_pkg::alm_wb_req_t req;
  logic [11:0]          idx;
  logic                 valid_req;
  logic                 wr_en;
  logic                 hit_summary;
  logic                 hit_flags;
  logic                 hit_mask;
  logic                 hit_lane;
  logic                 hit_cal;
  logic                 word_ok;

  assign req         = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                         adr: wb_adr_i, dat: wb_dat_i};
  assign idx         = req.adr[13:2];
  assign word_ok     = (req.adr[1:0] == 2'h0);
  assign valid_req   = req.cyc & req.stb & ~wb_ack_o;
  assign wr_en       = valid_req & req.we;
  assign hit_summary = word_ok & (idx == `ALM_IDX_SUMMARY);
  assign hit_flags   = word_ok & (idx == `ALM_IDX_FLAG_BANK);
  assign hit_mask    = word_ok & (idx == `ALM_IDX_MASK);
  assign hit_lane    = word_ok & (idx == `ALM_IDX_LANE_FAULT);
  assign hit_cal     = word_ok & (idx == `ALM_IDX_CAL_SEL);

  // ==========================================================================
  // Lane fault register
  // ==========================================================================
  logic [15:0] lane_fault;
  logic [15:0] lane_clr;
  logic [15:0] lane_wdat;

  assign lane_wdat = {req.sel[1] ? req.dat[15:8] : 8'h00,
                      req.sel[0] ? req.dat[7:0]  : 8'h00};
  // RQ9 RQ12 write one clears
  assign lane_clr  = (wr_en & hit_lane) ? lane_wdat : 16'h0000;

  genvar gi;
  generate
    for (gi = 0; gi < `ALM_NUM_LANES; gi++) begin : g_lane
      // RQ8 RQ10 RQ11 lane set wins
      alm_sticky_bit #(
        .RST_VAL (1'b1)
      ) u_lane (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (lane_fifo_fault_i[gi]),
        .clr_i  (lane_clr[gi]),
        .flag_o (lane_fault[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Alarm flag bank
  // ==========================================================================
  alm_pkg::alm_src_t src_set;
  logic [5:0]        flags;
  logic [5:0]        flag_clr;

  // RQ16 any active lane faults
  assign src_set.fifo_fault       = |(lane_fifo_fault_i & lane_active_i);
  assign src_set.lock_loss        = lock_loss_i;
  assign src_set.link_fault       = link_fault_i;
  assign src_set.realign_event    = realign_event_i;
  assign src_set.osc_phase_upset  = osc_phase_upset_i;
  assign src_set.divider_mismatch = divider_mismatch_i;
  assign flag_clr = (wr_en & hit_flags & req.sel[0]) ? req.dat[5:0] : 6'h00;

  generate
    for (gi = 0; gi < `ALM_NUM_SRC; gi++) begin : g_flag
      // RQ15 sticky alarm flags
      alm_sticky_bit #(
        .RST_VAL (1'b1)
      ) u_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (src_set[gi]),
        .clr_i  (flag_clr[gi]),
        .flag_o (flags[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Mask and pin select registers
  // ==========================================================================
  logic [5:0] mask_q;
  logic [5:0] mask_d;
  logic [1:0] reserved_q;
  logic [1:0] reserved_d;
  logic [1:0] cal_sel_q;
  logic [1:0] cal_sel_d;
  logic       wr_mask;
  logic       wr_cal;

  assign wr_mask    = wr_en & hit_mask & req.sel[0];
  assign wr_cal     = wr_en & hit_cal & req.sel[0];
  // RQ12 mask write stores
  assign mask_d     = wr_mask ? req.dat[5:0] : mask_q;
  // RQ6 reserved bits stored
  assign reserved_d = wr_mask ? req.dat[7:6] : reserved_q;
  assign cal_sel_d  = wr_cal ? req.dat[1:0] : cal_sel_q;

  // RQ7 all masked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= `ALARM_SOURCE_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // The reserved bits only read back what was written; no logic uses them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reserved_q <= `ALM_RSV_RST;
    end else begin
      reserved_q <= reserved_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_sel_q <= `ALM_CAL_SEL_RST;
    end else begin
      cal_sel_q <= cal_sel_d;
    end
  end

  // ==========================================================================
  // Summary alarm
  // ==========================================================================
  logic       suppress_fifo_fault;
  logic       suppress_lock_loss;
  logic       suppress_link_fault;
  logic       suppress_realign_event;
  logic       suppress_osc_phase_upset;
  logic       suppress_divider_mismatch;
  logic       fifo_fault_flag;
  logic       lock_loss_flag;
  logic       link_fault_flag;
  logic       realign_event_flag;
  logic       osc_phase_upset_flag;
  logic       divider_mismatch_flag;
  logic [5:0] live;
  logic       summary;

  // Mask fields in register bit order.
  assign suppress_fifo_fault       = mask_q[`ALM_BIT_FIFO];
  assign suppress_lock_loss        = mask_q[`ALM_BIT_LOCK];
  assign suppress_link_fault       = mask_q[`ALM_BIT_LINK];
  assign suppress_realign_event    = mask_q[`ALM_BIT_REALIGN];
  assign suppress_osc_phase_upset  = mask_q[`ALM_BIT_OSC];
  assign suppress_divider_mismatch = mask_q[`ALM_BIT_DIV];

  // Sticky flags in register bit order.
  assign fifo_fault_flag           = flags[`ALM_BIT_FIFO];
  assign lock_loss_flag            = flags[`ALM_BIT_LOCK];
  assign link_fault_flag           = flags[`ALM_BIT_LINK];
  assign realign_event_flag        = flags[`ALM_BIT_REALIGN];
  assign osc_phase_upset_flag      = flags[`ALM_BIT_OSC];
  assign divider_mismatch_flag     = flags[`ALM_BIT_DIV];

  // RQ1 fifo mask
  assign live[`ALM_BIT_FIFO]    = fifo_fault_flag       & ~suppress_fifo_fault;
  // RQ2 lock mask
  assign live[`ALM_BIT_LOCK]    = lock_loss_flag        & ~suppress_lock_loss;
  // RQ3 link mask
  assign live[`ALM_BIT_LINK]    = link_fault_flag       & ~suppress_link_fault;
  // RQ4 realign mask
  assign live[`ALM_BIT_REALIGN] = realign_event_flag    & ~suppress_realign_event;
  // RQ5 oscillator mask
  assign live[`ALM_BIT_OSC]     = osc_phase_upset_flag  & ~suppress_osc_phase_upset;
  // RQ6 divider mask
  assign live[`ALM_BIT_DIV]     = divider_mismatch_flag & ~suppress_divider_mismatch;
  // The summary is combinational, so irq_o lags any flag or mask change by one register.
  // RQ14 summary of unmasked
  assign summary = |live;

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [31:0] rd_summary;
  logic [31:0] rd_flags;
  logic [31:0] rd_mask;
  logic [31:0] rd_lane;
  logic [31:0] rd_cal;
  logic [31:0] rdata;

  // Each word is zero unless its register is addressed, so the words OR together.
  assign rd_summary = hit_summary ? {31'h0, summary} : 32'h0;
  assign rd_flags   = hit_flags   ? {26'h0, flags} : 32'h0;
  assign rd_mask    = hit_mask    ? {24'h0, reserved_q, mask_q} : 32'h0;
  assign rd_lane    = hit_lane    ? {16'h0, lane_fault} : 32'h0;
  assign rd_cal     = hit_cal     ? {30'h0, cal_sel_q} : 32'h0;
  assign rdata      = rd_summary
                    | rd_flags
                    | rd_mask
                    | rd_lane
                    | rd_cal;

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  logic        cal_pin_d;
  logic        irq_d;
  logic        ack_d;
  logic [31:0] dat_d;

  // RQ17 alarm onto pin
  assign cal_pin_d = (cal_sel_q == `ALM_CAL_SEL_ALARM) ? summary : cal_status_i;
  assign irq_d     = summary;
  // valid_req excludes the ack cycle, so ack is one cycle wide even when a strobe is held too long.
  assign ack_d     = valid_req;
  // Data is zero outside an acknowledged read so stale words never reach the bus.
  assign dat_d     = (valid_req & ~req.we) ? rdata : `ALM_RDATA_RST;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `ALM_RDATA_RST;
    end else begin
      wb_dat_o <= dat_d;
    end
  end

  // RQ13 one cycle update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_d;
    end
  end

  // Select codes other than the alarm code pass the normal calibration status.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_status_pin_o <= 1'b0;
    end else begin
      cal_status_pin_o <= cal_pin_d;
    end
  end

endmodule

// ==== testbench/alm_ctrl_asserts.sv ====
// Port assertions of the alarm block.
// Assumes it is bound into alm_ctrl.
`timescale 1ns/1ps
module alm_ctrl_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [15:0] lane_fifo_fault_i,
  input wire logic        irq_o
);
  // ==================
  // Mask shadow and properties.
  logic [7:0] msk_q;
  wire logic  take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) msk_q <= 8'h3f;
    else if (take_w && wb_we_i && wb_adr_i == 14'hb08 && wb_sel_i[0]) msk_q <= wb_dat_i[7:0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rd_s(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a: assert property (take_w |=> wb_ack_o) else $error("no ack");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
  unmapped_zero_a: assert property (rd_s(14'hb0c) |-> wb_dat_o == 32'h0) else $error("bad hole");
  reset_quiet_a:
    assert property (disable iff (1'h0) rst_i |=> !wb_ack_o && !irq_o) else $error("reset");
  lane_sticky_a:
    assert property (rd_s(14'hb10) |-> (wb_dat_o[15:0] & $past(lane_fifo_fault_i, 2))
      == $past(lane_fifo_fault_i, 2)) else $error("lane bit lost");
  mask_store_a:
    assert property (rd_s(14'hb08) |-> wb_dat_o[7:0] == msk_q) else $error("mask lost");
  irq_masked_a:
    assert property (msk_q[5:0] == 6'h3f |=> !irq_o) else $error("masked irq");
endmodule
bind alm_ctrl alm_ctrl_asserts u_chk (.*);

// ==== testbench/alm_ctrl_test.sv ====
// Bench of alm_ctrl against a register model.
// Assumes the design and checker compile first.
`timescale 1ns/1ps
module alm_ctrl_test;
  // ==================
  // Stimulus, model and checks.
  logic        clk_i = 1'h0, rst_i = 1'h1, cal_status_i = 1'h0;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic        wb_ack_o, cal_status_pin_o, irq_o;
  wire logic   lock_loss_i, link_fault_i, realign_event_i, osc_phase_upset_i, divider_mismatch_i;
  logic [4:0]  evs = 5'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [13:0] wb_adr_i = 14'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [15:0] lane_fifo_fault_i = 16'h0, lane_active_i = 16'hffff, lan = 16'hffff;
  logic [7:0]  msk = 8'h3f, m;
  logic [5:0]  flg = 6'h3f;
  int          err_count = 0, compares = 0, seed = 32'he003baa2;
  assign {lock_loss_i, link_fault_i, realign_event_i, osc_phase_upset_i, divider_mismatch_i} = evs;
  alm_ctrl dut (.*);
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  function automatic logic sum();
    return |(flg & ~msk[5:0]);
  endfunction
  task automatic cmp(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: %h vs %h", $time, s, e);
    end
  endtask
  // A read compares its data with d, a write sends d.
  task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    if (!w) cmp(wb_dat_o, d);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic pulse(input int b, input logic [15:0] lf);
    @(posedge clk_i);
    if (b == 5) lane_fifo_fault_i <= lf;
    else evs <= 5'(1 << b);
    @(posedge clk_i);
    lane_fifo_fault_i <= 16'h0;
    evs <= 5'h0;
    lan = lan | (b == 5 ? lf : 16'h0);
    if (b != 5 || |(lf & lane_active_i)) flg[b] = 1'h1;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic clr;
    wb(1'h1, 14'hb04, 32'h3f);
    wb(1'h1, 14'hb10, 32'hffff);
    flg = 6'h0;
    lan = 16'h0;
  endtask
  task wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 14'hb08, 32'h3f);
    wb(1'h0, 14'hb10, 32'hffff);
    wb(1'h0, 14'hb04, 32'h3f);
    wb(1'h1, 14'hb10, 32'h0);
    wb(1'h0, 14'hb10, 32'hffff);
    clr();
    wb(1'h0, 14'hb10, 32'h0);
    for (int i = 0; i < 6; i++) begin
      m = 8'($random(seed));
      m[i] = 1'h0;
      msk = m;
      wb(1'h1, 14'hb08, {24'h0, m});
      wb(1'h0, 14'hb08, {24'h0, m});
      pulse(i, 16'h1 << i);
      cmp(32'(irq_o), 32'(sum()));
      wb(1'h0, 14'hb00, 32'(sum()));
      clr();
      wb(1'h1, 14'hb08, 32'h3f);
      msk = 8'h3f;
      pulse(i, 16'h1 << i);
      cmp(32'(irq_o), 32'h0);
      clr();
    end
    lane_active_i <= 16'($random(seed)) & 16'hff0f;
    pulse(5, 16'h00f0);
    wb(1'h0, 14'hb04, {26'h0, flg});
    wb(1'h0, 14'hb10, {16'h0, lan});
    lane_active_i <= 16'hffff;
    lane_fifo_fault_i <= 16'h0008;
    clr();
    lan = 16'h0008;
    flg[5] = 1'h1;
    wb(1'h0, 14'hb10, {16'h0, lan});
    wb(1'h0, 14'hb0c, 32'h0);
    lane_fifo_fault_i <= 16'h0;
    msk = 8'h0;
    wb(1'h1, 14'hb08, 32'h0);
    wb(1'h1, 14'hb18, 32'h1);
    repeat (2) @(posedge clk_i);
    cmp(32'(cal_status_pin_o), 32'(sum()));
    wb(1'h1, 14'hb18, 32'h0);
    repeat (2) @(posedge clk_i);
    cmp(32'(cal_status_pin_o), 32'h0);
    wrap_up();
  end
endmodule
